// ---- common/jcid_pkg.sv ----
package jcid_pkg;

    // ==================================================
    // widths and sizes
    localparam int IR_LEN      = 8;
    localparam int ID_LEN      = 32;
    localparam int ADDR_LEN    = 10;
    localparam int SIG_LEN     = 32;
    localparam int COL_LEN     = 90;
    localparam int BSR_LEN     = 16;
    localparam int NUM_COLS    = 1024;
    localparam int TAP_LINES   = 10;
    // arbitrary neutral identification value, lsb one as the standard asks
    localparam logic [ID_LEN-1:0] ID_VALUE_DEF = 32'h0000_0001;

    // ==================================================
    // opcodes
    localparam logic [IR_LEN-1:0] OP_EXTEST      = 8'h00;
    localparam logic [IR_LEN-1:0] OP_ADDR_SHIFT  = 8'h01;
    localparam logic [IR_LEN-1:0] OP_COL_SHIFT   = 8'h02;
    localparam logic [IR_LEN-1:0] OP_ERASE_ALL   = 8'h03;
    localparam logic [IR_LEN-1:0] OP_WRITE_COL   = 8'h07;
    localparam logic [IR_LEN-1:0] OP_LOCK        = 8'h09;
    localparam logic [IR_LEN-1:0] OP_READ_COL    = 8'h0A;
    localparam logic [IR_LEN-1:0] OP_DISCHARGE   = 8'h14;
    localparam logic [IR_LEN-1:0] OP_PROG_ON     = 8'h15;
    localparam logic [IR_LEN-1:0] OP_ID          = 8'h16;
    localparam logic [IR_LEN-1:0] OP_SIG_READ    = 8'h17;
    localparam logic [IR_LEN-1:0] OP_HIGHZ       = 8'h18;
    localparam logic [IR_LEN-1:0] OP_SIG_STORE   = 8'h1A;
    localparam logic [IR_LEN-1:0] OP_SAMPLE      = 8'h1C;
    localparam logic [IR_LEN-1:0] OP_PROG_OFF    = 8'h1E;
    localparam logic [IR_LEN-1:0] OP_CLAMP       = 8'h20;
    localparam logic [IR_LEN-1:0] OP_DONE_CLR    = 8'h24;
    localparam logic [IR_LEN-1:0] OP_WRITE_STEP  = 8'h27;
    localparam logic [IR_LEN-1:0] OP_READ_STEP   = 8'h2A;
    localparam logic [IR_LEN-1:0] OP_INTEST      = 8'h2C;
    localparam logic [IR_LEN-1:0] OP_DONE_SET    = 8'h2F;
    localparam logic [IR_LEN-1:0] OP_HOLD_PINS   = 8'h30;

    // ==================================================
    // types
    typedef enum logic [2:0] {
        PATH_BYPASS, PATH_BSR, PATH_ID, PATH_ADDR, PATH_COL, PATH_SIG
    } jcid_path_t;

    typedef enum logic [2:0] {
        NV_NONE, NV_ERASE, NV_WRITE, NV_WRITE_STEP, NV_READ, NV_READ_STEP,
        NV_LOCK, NV_SIG_STORE
    } jcid_nvop_t;

    // ==================================================
    // decode helpers
    function automatic jcid_path_t path_of(input logic [IR_LEN-1:0] op);
        if (op[IR_LEN-1])                                  return PATH_BYPASS;
        else if (op == OP_EXTEST || op == OP_SAMPLE)       return PATH_BSR;
        else if (op == OP_CLAMP || op == OP_HOLD_PINS)     return PATH_BYPASS;
        else if (op == OP_ID)                              return PATH_ID;
        else if (op == OP_ADDR_SHIFT)                      return PATH_ADDR;
        else if (op == OP_COL_SHIFT || op == OP_READ_COL
                 || op == OP_READ_STEP)                    return PATH_COL;
        else if (op == OP_SIG_READ || op == OP_SIG_STORE)  return PATH_SIG;
        else                                               return PATH_BYPASS;
    endfunction

    function automatic jcid_nvop_t nvop_of(input logic [IR_LEN-1:0] op);
        case (op)
            OP_ERASE_ALL:  return NV_ERASE;
            OP_WRITE_COL:  return NV_WRITE;
            OP_WRITE_STEP: return NV_WRITE_STEP;
            OP_READ_COL:   return NV_READ;
            OP_READ_STEP:  return NV_READ_STEP;
            OP_LOCK:       return NV_LOCK;
            OP_SIG_STORE:  return NV_SIG_STORE;
            default:       return NV_NONE;
        endcase
    endfunction

endpackage

// ---- hw/jcid_sync.sv ----
`timescale 1ns/1ns
module jcid_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // foreign levels
    input  wire logic [W-1:0] async_in,
    // levels in clk_sys domain
    output logic      [W-1:0] sync_out
);

    // ==================================================
    // two-flop synchroniser
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule // jcid_sync

// ---- hw/jcid_decoder.sv ----
`timescale 1ns/1ns
module jcid_decoder
    import jcid_pkg::*;
#(
    parameter logic [ID_LEN-1:0] ID_VALUE = ID_VALUE_DEF
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset,
    // test port pins
    input  wire logic               tck,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdo_oe_n,
    // tap controller state strobes
    input  wire logic               tap_reset,
    input  wire logic               tap_capture_ir,
    input  wire logic               tap_shift_ir,
    input  wire logic               tap_update_ir,
    input  wire logic               tap_capture_dr,
    input  wire logic               tap_shift_dr,
    input  wire logic               tap_update_dr,
    input  wire logic               tap_run_idle,
    // device pins and test controls
    input  wire logic [BSR_LEN-1:0] pin_state,
    output logic [BSR_LEN-1:0]      bsr_pin_value,
    output logic                    pins_from_bsr,
    output logic                    outputs_highz,
    output logic                    extest_mode,
    output logic                    intest_mode,
    // configuration status
    output logic                    prog_mode,
    output logic                    config_valid,
    output logic                    readout_lock_bit,
    output logic                    supply_discharge
);

    // ==================================================
    // input synchronisation and tck edges
    logic [TAP_LINES+BSR_LEN-1:0] sync_q;
    logic               tck_s, tdi_s, tlr_s, cir_s, sir_s, uir_s, cdr_s, sdr_s, udr_s, rti_s;
    logic [BSR_LEN-1:0] pins_s;
    logic               tck_q, tck_rise, tck_fall, nv_start;

    jcid_sync #(.W(TAP_LINES + BSR_LEN)) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({pin_state, tap_run_idle, tap_update_dr, tap_shift_dr, tap_capture_dr,
                    tap_update_ir, tap_shift_ir, tap_capture_ir, tap_reset, tdi, tck}),
        .sync_out (sync_q)
    );

    assign {pins_s, rti_s, udr_s, sdr_s, cdr_s, uir_s, sir_s, cir_s, tlr_s, tdi_s, tck_s}
        = sync_q;
    assign tck_rise = tck_s & ~tck_q;
    assign tck_fall = ~tck_s & tck_q;

    // ==================================================
    // state
    logic [IR_LEN-1:0]   ir, ir_shift, next_ir, next_ir_shift;
    logic [BSR_LEN-1:0]  bsr_shift, next_bsr_shift, next_bsr_pin_value;
    logic [ID_LEN-1:0]   id_shift, next_id_shift;
    logic [ADDR_LEN-1:0] addr, next_addr;
    logic [COL_LEN-1:0]  col, next_col, rd_data;
    logic [SIG_LEN-1:0]  sig, sig_nv, next_sig, next_sig_nv;
    logic [NUM_COLS-1:0] col_valid, next_col_valid;
    logic                bypass, next_bypass, rti_prev, next_rti_prev;
    logic                next_prog_mode, next_config_valid, next_lock, next_discharge;
    logic                next_tdo, next_tdo_oe_n, mem_we;
    logic                next_pins_from_bsr, next_highz, next_extest, next_intest;
    jcid_nvop_t          pend, next_pend;
    jcid_path_t          path;
    logic [COL_LEN-1:0]  nv_cols [NUM_COLS];

    function automatic logic [ADDR_LEN-1:0] inc_addr(input logic [ADDR_LEN-1:0] a);
        return ADDR_LEN'(a + 1'b1);
    endfunction

    assign path     = path_of(ir);
    assign nv_start = tck_rise & rti_s & ~rti_prev & (pend != NV_NONE);
    assign rd_data  = (col_valid[addr] && !readout_lock_bit) ? nv_cols[addr] : '0;

    // ==================================================
    // next-state logic
    always_comb begin
        next_ir        = ir;
        next_ir_shift  = ir_shift;
        next_bsr_shift = bsr_shift;
        next_id_shift  = id_shift;
        next_addr      = addr;
        next_col       = col;
        next_sig       = sig;
        next_sig_nv    = sig_nv;
        next_col_valid = col_valid;
        next_bypass    = bypass;
        next_rti_prev  = rti_prev;
        next_prog_mode = prog_mode;
        next_config_valid  = config_valid;
        next_lock      = readout_lock_bit;
        next_pend      = pend;
        next_discharge = 1'b0;
        next_tdo       = tdo;
        next_tdo_oe_n  = tdo_oe_n;
        next_bsr_pin_value = bsr_pin_value;
        mem_we         = 1'b0;
        if (tck_rise) begin
            next_rti_prev = rti_s;
            if (tlr_s) begin
                next_ir   = OP_ID;
                next_pend = NV_NONE;
            end else if (cir_s) begin
                next_ir_shift = OP_ID;
            end else if (sir_s) begin
                next_ir_shift = {tdi_s, ir_shift[IR_LEN-1:1]};
            end else if (uir_s) begin
                next_ir   = ir_shift;
                next_pend = nvop_of(ir_shift);
                case (ir_shift)
                    OP_PROG_ON:   next_prog_mode    = 1'b1;
                    OP_PROG_OFF:  next_prog_mode    = 1'b0;
                    OP_DONE_CLR:  next_config_valid = 1'b0;
                    OP_DONE_SET:  next_config_valid = 1'b1;
                    OP_SIG_READ:  next_sig          = sig_nv;
                    OP_DISCHARGE: next_discharge    = 1'b1;
                    default: ;
                endcase
            end else if (cdr_s) begin
                case (path)
                    PATH_BSR:    next_bsr_shift = pins_s;
                    PATH_ID:     next_id_shift  = ID_VALUE;
                    PATH_BYPASS: next_bypass    = 1'b0;
                    default: ;
                endcase
            end else if (sdr_s) begin
                case (path)
                    PATH_BSR:  next_bsr_shift = {tdi_s, bsr_shift[BSR_LEN-1:1]};
                    PATH_ID:   next_id_shift  = {tdi_s, id_shift[ID_LEN-1:1]};
                    PATH_ADDR: next_addr      = {tdi_s, addr[ADDR_LEN-1:1]};
                    PATH_COL:  next_col       = {tdi_s, col[COL_LEN-1:1]};
                    PATH_SIG:  next_sig       = {tdi_s, sig[SIG_LEN-1:1]};
                    default:   next_bypass    = tdi_s;
                endcase
            end else if (udr_s && path == PATH_BSR) begin
                next_bsr_pin_value = bsr_shift;
            end
            if (nv_start) begin
                next_pend = NV_NONE;
                if (prog_mode) begin
                    case (pend)
                        NV_ERASE: begin
                            next_col_valid    = '0;
                            next_sig_nv       = '0;
                            next_lock         = 1'b0;
                            next_config_valid = 1'b0;
                        end
                        NV_WRITE: begin
                            mem_we               = 1'b1;
                            next_col_valid[addr] = 1'b1;
                        end
                        NV_WRITE_STEP: begin
                            mem_we               = 1'b1;
                            next_col_valid[addr] = 1'b1;
                            next_addr            = inc_addr(addr);
                        end
                        NV_READ:      next_col = rd_data;
                        NV_READ_STEP: begin
                            next_col  = rd_data;
                            next_addr = inc_addr(addr);
                        end
                        NV_LOCK:      next_lock   = 1'b1;
                        NV_SIG_STORE: next_sig_nv = sig;
                        default: ;
                    endcase
                end
            end
        end
        if (tck_fall) begin
            // capture fall already shows bit 0, ready for the first shift
            next_tdo_oe_n = ~(cir_s | sir_s | cdr_s | sdr_s);
            if (cir_s || sir_s) begin
                next_tdo = ir_shift[0];
            end else if (cdr_s || sdr_s) begin
                case (path)
                    PATH_BSR:  next_tdo = bsr_shift[0];
                    PATH_ID:   next_tdo = id_shift[0];
                    PATH_ADDR: next_tdo = addr[0];
                    PATH_COL:  next_tdo = col[0] & ~readout_lock_bit;
                    PATH_SIG:  next_tdo = sig[0];
                    default:   next_tdo = bypass;
                endcase
            end
        end
        next_highz         = (next_ir == OP_HIGHZ);
        next_pins_from_bsr = (next_ir == OP_CLAMP) || (next_ir == OP_HOLD_PINS)
                             || (next_ir == OP_EXTEST);
        next_extest        = (next_ir == OP_EXTEST);
        next_intest        = (next_ir == OP_INTEST);
    end

    // ==================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tck_q            <= 1'b0;
            ir               <= OP_ID;
            ir_shift         <= OP_ID;
            bsr_shift        <= '0;
            id_shift         <= '0;
            addr             <= '0;
            col              <= '0;
            sig              <= '0;
            sig_nv           <= '0;
            col_valid        <= '0;
            bypass           <= 1'b0;
            rti_prev         <= 1'b0;
            prog_mode        <= 1'b0;
            config_valid     <= 1'b0;
            readout_lock_bit <= 1'b0;
            pend             <= NV_NONE;
            supply_discharge <= 1'b0;
            tdo              <= 1'b0;
            tdo_oe_n         <= 1'b1;
            bsr_pin_value    <= '0;
            outputs_highz    <= 1'b0;
            pins_from_bsr    <= 1'b0;
            extest_mode      <= 1'b0;
            intest_mode      <= 1'b0;
        end else begin
            tck_q            <= tck_s;
            ir               <= next_ir;
            ir_shift         <= next_ir_shift;
            bsr_shift        <= next_bsr_shift;
            id_shift         <= next_id_shift;
            addr             <= next_addr;
            col              <= next_col;
            sig              <= next_sig;
            sig_nv           <= next_sig_nv;
            col_valid        <= next_col_valid;
            bypass           <= next_bypass;
            rti_prev         <= next_rti_prev;
            prog_mode        <= next_prog_mode;
            config_valid     <= next_config_valid;
            readout_lock_bit <= next_lock;
            pend             <= next_pend;
            supply_discharge <= next_discharge;
            tdo              <= next_tdo;
            tdo_oe_n         <= next_tdo_oe_n;
            bsr_pin_value    <= next_bsr_pin_value;
            outputs_highz    <= next_highz;
            pins_from_bsr    <= next_pins_from_bsr;
            extest_mode      <= next_extest;
            intest_mode      <= next_intest;
        end
    end

    // column array, validity tracked by col_valid
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            nv_cols[addr] <= col;
        end
    end

    // ==================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_ir_load;
        tck_rise && uir_s && !tlr_s |=> ir == $past(ir_shift);
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("ir not loaded");

    property p_ir_capture;
        tck_rise && cir_s && !tlr_s |=> ir_shift == OP_ID;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("capture not id");

    property p_tlr_id;
        tck_rise && tlr_s |=> ir == OP_ID ##0 path == PATH_ID;
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset not id");

    property p_bypass;
        tck_rise && sdr_s && !(tlr_s || cir_s || sir_s || uir_s || cdr_s || nv_start)
            && ir[IR_LEN-1] |=> bypass == $past(tdi_s) && $stable(addr) && $stable(col);
    endproperty
    a_bypass: assert property (p_bypass) else $error("msb not bypass");

    property p_prog_on;
        tck_rise && uir_s && !tlr_s && ir_shift == OP_PROG_ON |=> prog_mode;
    endproperty
    a_prog_on: assert property (p_prog_on) else $error("prog not set");

    property p_gate;
        nv_start && !prog_mode |=> $stable(col_valid) && $stable(sig_nv)
                                   && $stable(readout_lock_bit);
    endproperty
    a_gate: assert property (p_gate) else $error("array changed outside prog");

    property p_write_step;
        nv_start && prog_mode && pend == NV_WRITE_STEP
            |=> addr == inc_addr($past(addr)) && col_valid[$past(addr)];
    endproperty
    a_write_step: assert property (p_write_step) else $error("write step bad");

    property p_erase;
        nv_start && prog_mode && pend == NV_ERASE
            |=> !readout_lock_bit && sig_nv == '0 && col_valid == '0;
    endproperty
    a_erase: assert property (p_erase) else $error("erase incomplete");

    property p_lock_read;
        nv_start && prog_mode && readout_lock_bit && pend == NV_READ |=> col == '0;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("locked read leaked");

    property p_highz;
        ir == OP_HIGHZ ##1 ir == OP_HIGHZ |-> outputs_highz;
    endproperty
    a_highz: assert property (p_highz) else $error("outputs not high-z");

    property p_tdo_id;
        tck_fall && (cdr_s || sdr_s) && path == PATH_ID
            |=> tdo == $past(id_shift[0]) && !tdo_oe_n;
    endproperty
    a_tdo_id: assert property (p_tdo_id) else $error("id bit not on tdo");

    c_erase:    cover property (nv_start && prog_mode && pend == NV_ERASE);
    c_wstep:    cover property (nv_start && prog_mode && pend == NV_WRITE_STEP);
    c_sig_read: cover property (tck_rise && uir_s && ir_shift == OP_SIG_READ);
    c_highz:    cover property (outputs_highz);

endmodule // jcid_decoder

// ---- bench/jcid_jtag_host.sv ----
`timescale 1ns/1ns
module jcid_jtag_host (
    // clock
    input  wire logic       clk_sys,
    // test port pins
    output logic            tck,
    output logic            tdi,
    input  wire logic       tdo,
    // tap state strobes: reset, cap_ir, sh_ir, up_ir, cap_dr, sh_dr, up_dr, run
    output logic [7:0]      st
);
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        st  = 8'h00;
    end
    // ==========
    // one tck period, tdo sampled just before the rise
    task automatic tick(input logic [7:0] s, input logic d, output logic q);
        @(negedge clk_sys);
        st  = s;
        tdi = d;
        repeat (8) @(negedge clk_sys);
        q   = tdo;
        tck = 1'b1;
        repeat (8) @(negedge clk_sys);
        tck = 1'b0;
    endtask
    // lsb first: capture, n shifts, update
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        tick(ir ? 8'h40 : 8'h08, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            tick(ir ? 8'h20 : 8'h04, din[i], q);
            dout[i] = q;
        end
        tick(ir ? 8'h10 : 8'h02, ~tdi, q);
        tdi = ~tdi;
    endtask
    // first rise in run-test/idle after update
    task automatic idle();
        logic q;
        tick(8'h01, ~tdi, q);
        st = 8'h00;
    endtask
endmodule // jcid_jtag_host

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import jcid_pkg::*;
    typedef struct {logic [7:0] op; logic [3:0] m; logic byp;} jcid_row_t;
    localparam logic [127:0] PAT = 128'h0000_0000_0255_F0F0_1234_8765_ABCD_EF01;
    logic clk_sys, reset, tck, tdi, tdo, tdo_oe_n, seen_dis;
    logic pins_from_bsr, outputs_highz, extest_mode, intest_mode;
    logic prog_mode, config_valid, readout_lock_bit, supply_discharge;
    logic [7:0]         st;
    logic [BSR_LEN-1:0] pin_state, bsr_pin_value;
    logic [127:0]       got, cap;
    int                 n_mismatch, num_checks;
    wire  [3:0]         modes = {pins_from_bsr, outputs_highz, extest_mode, intest_mode};
    // released tdo shows the inverse, so a stale bit cannot pass
    wire                tdo_pin = tdo_oe_n ? ~tdo : tdo;
    jcid_row_t rows [9] = '{'{8'h00, 4'b1010, 1'b0}, '{8'h18, 4'b0100, 1'b1},
        '{8'h20, 4'b1000, 1'b1}, '{8'h30, 4'b1000, 1'b1}, '{8'h2C, 4'b0001, 1'b0},
        '{8'h80, 4'b0000, 1'b1}, '{8'hFF, 4'b0000, 1'b1}, '{8'h3F, 4'b0000, 1'b1},
        '{8'h16, 4'b0000, 1'b0}};

    jcid_jtag_host h (.clk_sys(clk_sys), .tck(tck), .tdi(tdi), .tdo(tdo_pin), .st(st));
    jcid_decoder DUT (.clk_sys(clk_sys), .reset(reset), .tck(tck), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .tap_reset(st[7]), .tap_capture_ir(st[6]),
        .tap_shift_ir(st[5]), .tap_update_ir(st[4]), .tap_capture_dr(st[3]),
        .tap_shift_dr(st[2]), .tap_update_dr(st[1]), .tap_run_idle(st[0]),
        .pin_state(pin_state), .bsr_pin_value(bsr_pin_value),
        .pins_from_bsr(pins_from_bsr), .outputs_highz(outputs_highz),
        .extest_mode(extest_mode), .intest_mode(intest_mode), .prog_mode(prog_mode),
        .config_valid(config_valid), .readout_lock_bit(readout_lock_bit),
        .supply_discharge(supply_discharge));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        seen_dis <= reset ? 1'b0 : (seen_dis | (supply_discharge === 1'b1));

    // ==========
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ir(input logic [7:0] op);
        h.scan(1'b1, 8, {120'h0, op}, cap);
    endtask
    task automatic dr(input int n, input logic [127:0] din);
        h.scan(1'b0, n, din, got);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        n_mismatch++;
        report_and_stop();
    end

    // ==========
    initial begin
        reset = 1'b1;
        pin_state = 16'hA5C3;
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({tdo_oe_n, prog_mode, config_valid, readout_lock_bit}, 4'b1000);
        dr(32, 0);
        check(got, ID_VALUE_DEF);
        $display("test reset_id done");
        foreach (rows[i]) begin
            ir(rows[i].op);
            check(modes, rows[i].m);
            dr(8, 128'h5A);
            if (rows[i].byp) check(got, 128'hB4);
        end
        ir(8'h1C);
        dr(16, 128'h3C96);
        check(got, 128'hA5C3);
        check(bsr_pin_value, 16'h3C96);
        $display("test decode done");
        ir(8'h09);
        h.idle();
        check(readout_lock_bit, 1'b0);
        ir(8'h15);
        check(cap, 128'h16);
        check(prog_mode, 1'b1);
        ir(8'h01);
        dr(10, 128'h3FF);
        ir(8'h02);
        dr(90, PAT);
        ir(8'h27);
        h.idle();
        ir(8'h01);
        dr(10, 128'h3FF);
        check(got, 0);
        ir(8'h2A);
        h.idle();
        dr(90, 0);
        check(got, PAT);
        ir(8'h01);
        dr(10, 128'h5);
        check(got, 0);
        ir(8'h02);
        dr(90, 128'h1);
        ir(8'h07);
        h.idle();
        ir(8'h0A);
        h.idle();
        dr(90, 0);
        check(got, 128'h1);
        $display("test column done");
        ir(8'h09);
        h.idle();
        check(readout_lock_bit, 1'b1);
        ir(8'h0A);
        h.idle();
        dr(90, 0);
        check(got, 0);
        ir(8'h17);
        dr(32, 128'h1234_5678);
        ir(8'h1A);
        h.idle();
        ir(8'h17);
        dr(32, 0);
        check(got, 128'h1234_5678);
        ir(8'h2F);
        check(config_valid, 1'b1);
        ir(8'h24);
        check(config_valid, 1'b0);
        ir(8'h14);
        check(seen_dis, 1'b1);
        // erase ahead of any rewrite
        ir(8'h03);
        h.idle();
        check(readout_lock_bit, 1'b0);
        ir(8'h17);
        dr(32, 0);
        check(got, 0);
        ir(8'h1E);
        check(prog_mode, 1'b0);
        $display("test lock_sig_erase done");
        // test-logic reset from bypass, then a system reset in mid-run
        ir(8'hFF);
        h.tick(8'h80, 1'b0, got[0]);
        dr(32, 0);
        check(got, ID_VALUE_DEF);
        ir(8'h15);
        ir(8'h2F);
        reset = 1'b1;
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({tdo_oe_n, prog_mode, config_valid, modes}, 7'b100_0000);
        dr(32, 0);
        check(got, ID_VALUE_DEF);
        $display("test resets done");
        report_and_stop();
    end
endmodule // testbench
